/* stm_pkg.sv */
// constants, types and helpers shared by the sequence table manager
package stm_pkg;
    localparam logic [7:0] OFF_CMD      = 8'h00;
    localparam logic [7:0] OFF_SEQ_ID   = 8'h04;
    localparam logic [7:0] OFF_STEP     = 8'h08;
    localparam logic [7:0] OFF_COUNT    = 8'h0c;
    localparam logic [7:0] OFF_WDATA    = 8'h10;
    localparam logic [7:0] OFF_WBYTE    = 8'h14;
    localparam logic [7:0] OFF_RDATA    = 8'h18;
    localparam logic [7:0] OFF_FUNC     = 8'h1c;
    localparam logic [7:0] OFF_FIRST    = 8'h20;
    localparam logic [7:0] OFF_CTRL     = 8'h24;
    localparam logic [7:0] OFF_STATUS   = 8'h28;
    localparam logic [7:0] OFF_RESULT   = 8'h2c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h34;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h38;
    localparam logic [7:0] OFF_PLAY_POS = 8'h3c;

    localparam logic [1:0] OP_NEW   = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_READ  = 2'h3;

    localparam logic [2:0] LAST_WORD = 3'h5;

    localparam logic [1:0] ADV_AUTO = 2'h0;
    localparam logic [1:0] ADV_COND = 2'h1;
    localparam logic [1:0] ADV_REP  = 2'h2;
    localparam logic [1:0] ADV_SING = 2'h3;

    localparam logic [1:0] FUNC_ARB  = 2'h0;
    localparam logic [1:0] FUNC_SEQ  = 2'h1;
    localparam logic [1:0] FUNC_SCEN = 2'h2;
    localparam logic [1:0] FUNC_RST  = 2'h0;

    localparam logic [31:0] END_IS_LAST = 32'hffffffff;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_STEP = 2;
    localparam int IRQ_WRAP = 3;
    localparam int IRQ_W    = 4;

    typedef enum logic [3:0] {
        C_IDLE  = 4'b0001,
        C_ALLOC = 4'b0010,
        C_WRITE = 4'b0100,
        C_READ  = 4'b1000
    } stm_cmd_st_t;

    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_RUN  = 3'b010,
        P_WAIT = 3'b100
    } stm_play_st_t;

    typedef struct packed {
        logic [31:0] seg_id;
        logic [31:0] loops;
        logic [31:0] adv;
        logic [31:0] marker;
        logic [31:0] start_addr;
        logic [31:0] end_addr;
    } stm_step_t;

    typedef struct packed {
        logic        valid;
        logic        marker;
        logic [31:0] segment;
        logic [31:0] addr;
    } stm_play_t;

    function automatic logic [31:0] step_word(input stm_step_t s, input logic [2:0] i);
        case (i)
            3'h0:    step_word = s.seg_id;
            3'h1:    step_word = s.loops;
            3'h2:    step_word = s.adv;
            3'h3:    step_word = s.marker;
            3'h4:    step_word = s.start_addr;
            default: step_word = s.end_addr;
        endcase
    endfunction : step_word
endpackage : stm_pkg

/* stm_table_mgr.sv */
// sequence table manager: apb command port, step table and playback sequencer
// Function
// - new sequence reserves consecutive entries, returns index of first entry
// - each step is stored as six 32-bit words
// - word order: segment, loops, advance, marker, start, end on write and read
// - loop count repeats the segment; valid 1 to 4G-1
// - advance word: 0 auto, 1 advance_on_condition, 2 repeat, 3 single
// - marker word 0 disables, 1 enables the step's marker
// - step playback begins at its start address
// - step ends at end address; all ones means segment's last sample
// - write command stores one or more consecutive steps from given step
// - unallocated id or step beyond length gives error and no access
// - read returns words of requested consecutive steps from given step
// - word list and binary byte block are interpreted identically
// - readable function mode selects segment, sequence or scenario play; here scenario mode refuses begin and stays idle
// - scenario and idle delay entries not offered on this path
// - playback chains and loops steps in programmed table order
module stm_table_mgr #(
    parameter int DEPTH = 524288
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              sample_en,
    input  wire logic              adv_trigger,
    input  wire logic [31:0]       seg_last_addr,
    output logic      [31:0]       seg_query_id,
    output stm_pkg::stm_play_t     play
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [32:0] DEPTH_W = 33'(DEPTH);

    stm_pkg::stm_step_t   tbl_mem [DEPTH];
    logic [31:0]          len_mem [DEPTH];

    stm_pkg::stm_cmd_st_t  cmd_q;
    stm_pkg::stm_play_st_t pst_q;
    stm_pkg::stm_step_t    wbuf_q, commit, cur_q, nxt_step;
    logic [31:0]  seq_id_q, step_q, count_q, first_q, result_q, rdata_q;
    logic [1:0]   func_q;
    logic [AW:0]  next_free_q;
    logic [AW-1:0] ptr_q, entry_q, seq_base_q, seq_last_q, nxt_entry;
    logic [31:0]  cursor_q, steps_left_q, loops_left_q, addr_q, end_eff;
    logic [2:0]   widx_q;
    logic [1:0]   bcnt_q;
    logic [23:0]  bacc_q;
    localparam int IRQ_W_L = stm_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_stat_q, irq_en_q, ev;
    logic         err_q;

    logic wr_acc, rd_acc, setup, mapped;
    logic cmd_go, begin_go, stop_go, ctrl_adv;
    logic word_stb, pop_stb, id_ok, range_ok, at_end, go_next, wrap;
    logic [31:0] word_val, sel_len, first_len;
    logic [AW-1:0] id_idx;

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign pready = 1'b1;

    always_comb begin
        unique case (paddr)
            stm_pkg::OFF_CMD, stm_pkg::OFF_SEQ_ID, stm_pkg::OFF_STEP, stm_pkg::OFF_COUNT,
            stm_pkg::OFF_WDATA, stm_pkg::OFF_WBYTE, stm_pkg::OFF_RDATA, stm_pkg::OFF_FUNC,
            stm_pkg::OFF_FIRST, stm_pkg::OFF_CTRL, stm_pkg::OFF_STATUS, stm_pkg::OFF_RESULT,
            stm_pkg::OFF_IRQ_STAT, stm_pkg::OFF_IRQ_EN, stm_pkg::OFF_IRQ_CLR,
            stm_pkg::OFF_PLAY_POS: mapped = 1'b1;
            default:               mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    assign cmd_go   = wr_acc && paddr == stm_pkg::OFF_CMD && cmd_q == stm_pkg::C_IDLE;
    assign begin_go = wr_acc && paddr == stm_pkg::OFF_CTRL && pwdata[0];
    assign stop_go  = wr_acc && paddr == stm_pkg::OFF_CTRL && pwdata[1];
    assign ctrl_adv = (wr_acc && paddr == stm_pkg::OFF_CTRL && pwdata[2]) | adv_trigger;

    assign id_idx   = seq_id_q[AW-1:0];
    assign sel_len  = len_mem[id_idx];
    assign id_ok    = {1'b0, seq_id_q} < 33'(next_free_q) && sel_len != 32'h0;
    assign range_ok = count_q != 32'h0 && {1'b0, step_q} + {1'b0, count_q} <= {1'b0, sel_len};

    // bytes of a binary block assemble msb first into the same word path
    assign word_stb = cmd_q == stm_pkg::C_WRITE && wr_acc &&
                      (paddr == stm_pkg::OFF_WDATA || (paddr == stm_pkg::OFF_WBYTE && bcnt_q == 2'h3));
    assign word_val = paddr == stm_pkg::OFF_WBYTE ? {bacc_q, pwdata[7:0]} : pwdata;
    assign pop_stb  = cmd_q == stm_pkg::C_READ && rd_acc && paddr == stm_pkg::OFF_RDATA;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= 2'h0;
            bacc_q <= 24'h0;
        end else if (cmd_q != stm_pkg::C_WRITE) begin
            bcnt_q <= 2'h0;
        end else if (wr_acc && paddr == stm_pkg::OFF_WBYTE) begin
            bcnt_q <= bcnt_q + 2'h1;
            bacc_q <= {bacc_q[15:0], pwdata[7:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_id_q <= 32'h0;
            step_q   <= 32'h0;
            count_q  <= 32'h0;
            first_q  <= 32'h0;
            func_q   <= stm_pkg::FUNC_RST;
            irq_en_q <= '0;
        end else if (wr_acc) begin
            unique case (paddr)
                stm_pkg::OFF_SEQ_ID: seq_id_q <= pwdata;
                stm_pkg::OFF_STEP:   step_q   <= pwdata;
                stm_pkg::OFF_COUNT:  count_q  <= pwdata;
                stm_pkg::OFF_FUNC:   func_q   <= pwdata[1:0];
                stm_pkg::OFF_FIRST:  first_q  <= pwdata;
                stm_pkg::OFF_IRQ_EN: irq_en_q <= pwdata[IRQ_W_L-1:0];
                default: ;
            endcase
        end
    end

    // incoming words land in field order
    always_comb begin
        commit = wbuf_q;
        commit.end_addr = word_val;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q        <= stm_pkg::C_IDLE;
            next_free_q  <= '0;
            result_q     <= 32'h0;
            cursor_q     <= 32'h0;
            ptr_q        <= '0;
            steps_left_q <= 32'h0;
            widx_q       <= 3'h0;
            wbuf_q       <= '0;
            err_q        <= 1'b0;
        end else begin
            unique case (cmd_q)
                stm_pkg::C_IDLE: begin
                    cursor_q <= 32'h0;
                    widx_q   <= 3'h0;
                    ptr_q    <= seq_id_q[AW-1:0] + step_q[AW-1:0];
                    steps_left_q <= count_q;
                    if (cmd_go) begin
                        err_q <= 1'b0;
                        if (pwdata[1:0] == stm_pkg::OP_NEW) begin
                            if (count_q == 32'h0 ||
                                33'(next_free_q) + {1'b0, count_q} > DEPTH_W) begin
                                err_q <= 1'b1;
                            end else begin
                                result_q <= 32'(next_free_q);
                                cmd_q    <= stm_pkg::C_ALLOC;
                            end
                        end else if (pwdata[1:0] == stm_pkg::OP_WRITE ||
                                     pwdata[1:0] == stm_pkg::OP_READ) begin
                            if (!id_ok || !range_ok) begin
                                err_q <= 1'b1;
                            end else if (pwdata[1:0] == stm_pkg::OP_WRITE) begin
                                cmd_q <= stm_pkg::C_WRITE;
                            end else begin
                                cmd_q <= stm_pkg::C_READ;
                            end
                        end else begin
                            err_q <= 1'b1;
                        end
                    end
                end
                stm_pkg::C_ALLOC: begin
                    cursor_q <= cursor_q + 32'h1;
                    if (cursor_q == count_q - 32'h1) begin
                        next_free_q <= next_free_q + (AW+1)'(count_q);
                        cmd_q       <= stm_pkg::C_IDLE;
                    end
                end
                stm_pkg::C_WRITE, stm_pkg::C_READ: begin
                    // six words per step, then move to the next entry
                    if (word_stb || pop_stb) begin
                        unique case (widx_q)
                            3'h0: wbuf_q.seg_id     <= word_val;
                            3'h1: wbuf_q.loops      <= word_val;
                            3'h2: wbuf_q.adv        <= word_val;
                            3'h3: wbuf_q.marker     <= word_val;
                            3'h4: wbuf_q.start_addr <= word_val;
                            default: ;
                        endcase
                        widx_q <= widx_q == stm_pkg::LAST_WORD ? 3'h0 : widx_q + 3'h1;
                        if (widx_q == stm_pkg::LAST_WORD) begin
                            ptr_q        <= ptr_q + 1'b1;
                            steps_left_q <= steps_left_q - 32'h1;
                            if (steps_left_q == 32'h1) begin
                                cmd_q <= stm_pkg::C_IDLE;
                            end
                        end
                    end
                end
                default: cmd_q <= stm_pkg::C_IDLE;
            endcase
        end
    end

    // each completed step is stored at the running entry
    always_ff @(posedge pclk) begin
        if (word_stb && widx_q == stm_pkg::LAST_WORD) begin
            tbl_mem[ptr_q] <= commit;
        end
    end

    // only the head entry of a sequence holds its length
    always_ff @(posedge pclk) begin
        if (cmd_q == stm_pkg::C_ALLOC) begin
            len_mem[AW'(result_q + cursor_q)] <= cursor_q == 32'h0 ? count_q : 32'h0;
        end
    end

    // read data sampled in setup, popped at access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
        end else if (setup) begin
            unique case (paddr)
                stm_pkg::OFF_SEQ_ID:   rdata_q <= seq_id_q;
                stm_pkg::OFF_STEP:     rdata_q <= step_q;
                stm_pkg::OFF_COUNT:    rdata_q <= count_q;
                stm_pkg::OFF_RDATA:    rdata_q <= cmd_q == stm_pkg::C_READ ?
                                                  stm_pkg::step_word(tbl_mem[ptr_q], widx_q) : 32'h0;
                stm_pkg::OFF_FUNC:     rdata_q <= {30'h0, func_q};
                stm_pkg::OFF_FIRST:    rdata_q <= first_q;
                stm_pkg::OFF_STATUS:   rdata_q <= {27'h0, err_q, pst_q == stm_pkg::P_WAIT,
                                                   pst_q != stm_pkg::P_IDLE,
                                                   cmd_q != stm_pkg::C_IDLE, 1'b0};
                stm_pkg::OFF_RESULT:   rdata_q <= result_q;
                stm_pkg::OFF_IRQ_STAT: rdata_q <= 32'(irq_stat_q);
                stm_pkg::OFF_IRQ_EN:   rdata_q <= 32'(irq_en_q);
                stm_pkg::OFF_PLAY_POS: rdata_q <= 32'(entry_q);
                default:               rdata_q <= 32'h0;
            endcase
        end
    end
    assign prdata = rdata_q;

    // playback sequencer
    assign first_len = len_mem[first_q[AW-1:0]];
    // all ones end address means the segment's last sample
    assign end_eff   = cur_q.end_addr == stm_pkg::END_IS_LAST ? seg_last_addr : cur_q.end_addr;
    assign at_end    = addr_q == end_eff;
    // next entry in table order, looping back to sequence start
    assign wrap      = entry_q == seq_last_q;
    assign nxt_entry = wrap ? seq_base_q : entry_q + 1'b1;
    assign nxt_step  = tbl_mem[nxt_entry];
    // auto moves after last loop, others on advance event
    assign go_next   = (pst_q == stm_pkg::P_RUN && sample_en && at_end && loops_left_q <= 32'h1 &&
                        cur_q.adv[1:0] == stm_pkg::ADV_AUTO) ||
                       (pst_q == stm_pkg::P_WAIT && ctrl_adv);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst_q        <= stm_pkg::P_IDLE;
            cur_q        <= '0;
            entry_q      <= '0;
            seq_base_q   <= '0;
            seq_last_q   <= '0;
            addr_q       <= 32'h0;
            loops_left_q <= 32'h0;
        end else if (stop_go) begin
            pst_q <= stm_pkg::P_IDLE;
        end else begin
            unique case (pst_q)
                stm_pkg::P_IDLE: begin
                    // scenario play is not offered here
                    if (begin_go && func_q != stm_pkg::FUNC_SCEN &&
                        {1'b0, first_q} < 33'(next_free_q) &&
                        (func_q == stm_pkg::FUNC_ARB || first_len != 32'h0)) begin
                        cur_q        <= tbl_mem[first_q[AW-1:0]];
                        entry_q      <= first_q[AW-1:0];
                        seq_base_q   <= first_q[AW-1:0];
                        seq_last_q   <= func_q == stm_pkg::FUNC_ARB ? first_q[AW-1:0] :
                                        AW'(first_q + first_len - 32'h1);
                        addr_q       <= tbl_mem[first_q[AW-1:0]].start_addr;
                        loops_left_q <= tbl_mem[first_q[AW-1:0]].loops;
                        pst_q        <= stm_pkg::P_RUN;
                    end
                end
                stm_pkg::P_RUN, stm_pkg::P_WAIT: begin
                    if (go_next) begin
                        // each step starts at its start address
                        cur_q        <= nxt_step;
                        entry_q      <= nxt_entry;
                        addr_q       <= nxt_step.start_addr;
                        loops_left_q <= nxt_step.loops;
                        pst_q        <= stm_pkg::P_RUN;
                    end else if (sample_en) begin
                        if (!at_end) begin
                            addr_q <= addr_q + 32'h1;
                        end else if (pst_q == stm_pkg::P_RUN && loops_left_q > 32'h1) begin
                            // repeat segment until loop count exhausted
                            loops_left_q <= loops_left_q - 32'h1;
                            addr_q       <= cur_q.start_addr;
                        end else if (pst_q == stm_pkg::P_RUN) begin
                            // non-auto modes hold for an advance event
                            pst_q  <= stm_pkg::P_WAIT;
                            addr_q <= cur_q.start_addr;
                        end else begin
                            addr_q <= cur_q.start_addr;
                        end
                    end
                end
                default: pst_q <= stm_pkg::P_IDLE;
            endcase
        end
    end

    // marker follows the step's enable word; single stops output in wait
    always_comb begin
        play.valid   = pst_q == stm_pkg::P_RUN ||
                       (pst_q == stm_pkg::P_WAIT && cur_q.adv[1:0] != stm_pkg::ADV_SING);
        play.marker  = play.valid && cur_q.marker == 32'h1;
        play.segment = cur_q.seg_id;
        play.addr    = addr_q;
    end
    assign seg_query_id = cur_q.seg_id;

    // sticky events, a set beats a clear in the same cycle
    always_comb begin
        ev = '0;
        ev[stm_pkg::IRQ_DONE] = cmd_q != stm_pkg::C_IDLE && (
                                (cmd_q == stm_pkg::C_ALLOC && cursor_q == count_q - 32'h1) ||
                                ((word_stb || pop_stb) && widx_q == stm_pkg::LAST_WORD &&
                                 steps_left_q == 32'h1));
        ev[stm_pkg::IRQ_ERR]  = cmd_go && cmd_q == stm_pkg::C_IDLE &&
                                !(pwdata[1:0] == stm_pkg::OP_NEW ? count_q != 32'h0 &&
                                  33'(next_free_q) + {1'b0, count_q} <= DEPTH_W :
                                  pwdata[1:0] != 2'h0 && id_ok && range_ok);
        ev[stm_pkg::IRQ_STEP] = go_next;
        ev[stm_pkg::IRQ_WRAP] = go_next && wrap;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else if (wr_acc && paddr == stm_pkg::OFF_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W_L-1:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_alloc_last;
        cmd_q == stm_pkg::C_ALLOC && cursor_q == count_q - 32'h1;
    endsequence
    a_alloc_bump_free: assert property (s_alloc_last |=>
        33'(next_free_q) == {1'b0, result_q} + {1'b0, count_q} && cmd_q == stm_pkg::C_IDLE)
        else $error("allocation did not advance the free pointer");
    a_six_word_step: assert property (word_stb && widx_q == stm_pkg::LAST_WORD |=>
        widx_q == 3'h0 && ptr_q == $past(ptr_q) + 1'b1)
        else $error("step did not close after six words");
    a_word_field_order: assert property (word_stb && widx_q == 3'h0 |=>
        wbuf_q.seg_id == $past(word_val))
        else $error("first word not taken as segment id");
    a_loop_repeat: assert property (pst_q == stm_pkg::P_RUN && sample_en && at_end &&
        loops_left_q > 32'h1 && !go_next && !stop_go |=>
        addr_q == cur_q.start_addr && loops_left_q == $past(loops_left_q) - 32'h1)
        else $error("segment loop not repeated");
    a_auto_advance: assert property (go_next && pst_q == stm_pkg::P_RUN && !stop_go |=>
        entry_q == $past(nxt_entry) && pst_q == stm_pkg::P_RUN)
        else $error("auto advance did not move to next entry");
    a_marker_gate: assert property (play.marker |->
        cur_q.marker == 32'h1 && pst_q != stm_pkg::P_IDLE)
        else $error("marker driven without enable");
    a_start_addr: assert property ($rose(pst_q == stm_pkg::P_RUN) |->
        addr_q == cur_q.start_addr)
        else $error("step did not start at start address");
    a_error_no_access: assert property (ev[stm_pkg::IRQ_ERR] |=>
        cmd_q == stm_pkg::C_IDLE && err_q && irq_stat_q[stm_pkg::IRQ_ERR])
        else $error("bad command was not refused");
    a_scenario_refused: assert property (begin_go && func_q == stm_pkg::FUNC_SCEN &&
        pst_q == stm_pkg::P_IDLE |=> pst_q == stm_pkg::P_IDLE)
        else $error("scenario play was started");
endmodule : stm_table_mgr

/* stm_seg_mem.sv */
// segment memory model answering last sample address queries
module stm_seg_mem (
    input  wire logic [31:0] seg_query_id,
    output logic      [31:0] seg_last_addr
);
    // fixed length per segment, offset from its id
    assign seg_last_addr = seg_query_id + 32'h7;
endmodule : stm_seg_mem

/* test_sequence_table_manager.sv */
// self-checking bench for the sequence table manager
module test_sequence_table_manager;
    timeunit 1ns;
    timeprecision 1ns;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic               sample_en, adv_trigger, rd_chk;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rdv, seg_last_addr, seg_query_id;
    logic [31:0]        exp_q[$];
    logic [31:0]        w[18];
    logic [31:0]        v[12] = '{32'h5, 32'h1, 32'h0, 32'h1, 32'h2, 32'h3,
                                  32'h6, 32'h1, 32'h3, 32'h0, 32'h0, 32'hffffffff};
    stm_pkg::stm_play_t play;
    int                 miscompares, compares, n, b;

    stm_table_mgr #(.DEPTH(64)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .sample_en, .adv_trigger,
        .seg_last_addr, .seg_query_id, .play);
    stm_seg_mem seg (.seg_query_id, .seg_last_addr);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : check

    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic c);
        int k;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, rd_chk} <= {1'b1, wr, a, d, c};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            miscompares++;
            wrap_up;
        end
        rdv = prdata;
        err = pslverr;
        {psel, penable, rd_chk} <= 3'h0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0, 1'b1);
    endtask : rd

    task automatic cmd(input logic [1:0] op);
        int k;
        apb(1'b1, stm_pkg::OFF_CMD, {30'h0, op}, 1'b0);
        // only allocation runs on its own; write and read wait for the host's words
        for (k = 0; k < 100; k++) begin
            apb(1'b0, stm_pkg::OFF_STATUS, 32'h0, 1'b0);
            if (rdv[1] === 1'b0 || op != stm_pkg::OP_NEW) break;
        end
        if (k == 100) begin
            miscompares++;
            wrap_up;
        end
    endtask : cmd

    // read results taken oldest first
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready && rd_chk && exp_q.size() > 0) begin
            check(exp_q.pop_front(), prdata);
        end
    end

    initial begin
        {psel, penable, pwrite, sample_en, adv_trigger, rd_chk, presetn} = 7'h0;
        {paddr, pwdata} = 40'h0;
        void'($urandom(9));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, stm_pkg::OFF_COUNT, 32'h3, 1'b0);
        cmd(stm_pkg::OP_NEW);
        rd(stm_pkg::OFF_RESULT, 32'h0);
        apb(1'b1, stm_pkg::OFF_COUNT, 32'h2, 1'b0);
        cmd(stm_pkg::OP_NEW);
        rd(stm_pkg::OFF_RESULT, 32'h3);
        apb(1'b1, stm_pkg::OFF_COUNT, 32'h3, 1'b0);
        cmd(stm_pkg::OP_WRITE);
        for (n = 0; n < 18; n++) begin
            w[n] = (n % 6 == 3) ? ($urandom & 32'h1) : $urandom;
            if (n < 12) apb(1'b1, stm_pkg::OFF_WDATA, w[n], 1'b0);
            else for (b = 3; b >= 0; b--) apb(1'b1, stm_pkg::OFF_WBYTE, {24'h0, w[n][8*b+:8]}, 1'b0);
        end
        cmd(stm_pkg::OP_READ);
        for (n = 0; n < 18; n++) rd(stm_pkg::OFF_RDATA, w[n]);
        apb(1'b1, stm_pkg::OFF_IRQ_EN, 32'h2, 1'b0);
        apb(1'b1, stm_pkg::OFF_STEP, 32'h2, 1'b0);
        cmd(stm_pkg::OP_WRITE);
        check(32'h10, rdv & 32'h10);
        check(32'h1, {31'h0, irq});
        apb(1'b1, stm_pkg::OFF_IRQ_CLR, 32'hf, 1'b0);
        apb(1'b1, 8'h40, 32'h0, 1'b0);
        check(32'h1, {31'h0, err});
        check(32'h0, {31'h0, irq});
        for (n = 2; n >= 0; n--) begin
            apb(1'b1, stm_pkg::OFF_FUNC, 32'(n), 1'b0);
            rd(stm_pkg::OFF_FUNC, 32'(n));
        end
        apb(1'b1, stm_pkg::OFF_FUNC, 32'h1, 1'b0);
        apb(1'b1, stm_pkg::OFF_CTRL, 32'h1, 1'b0);
        for (n = 0; n < 20 && play.valid !== 1'b1; n++) @(posedge pclk);
        check(32'h1, {31'h0, play.valid});
        check(w[4], play.addr);
        check(w[0], play.segment);
        check(w[3], {31'h0, play.marker});
        // second sequence: auto step into a single step that ends on the segment's last sample
        apb(1'b1, stm_pkg::OFF_CTRL, 32'h2, 1'b0);
        apb(1'b1, stm_pkg::OFF_SEQ_ID, 32'h3, 1'b0);
        apb(1'b1, stm_pkg::OFF_STEP, 32'h0, 1'b0);
        apb(1'b1, stm_pkg::OFF_COUNT, 32'h2, 1'b0);
        cmd(stm_pkg::OP_WRITE);
        for (n = 0; n < 12; n++) apb(1'b1, stm_pkg::OFF_WDATA, v[n], 1'b0);
        apb(1'b1, stm_pkg::OFF_FIRST, 32'h3, 1'b0);
        apb(1'b1, stm_pkg::OFF_CTRL, 32'h1, 1'b0);
        sample_en <= 1'b1;
        repeat (2) @(posedge pclk);
        sample_en <= 1'b0;
        @(posedge pclk);
        check(32'h6, play.segment);
        check(32'h0, play.addr);
        sample_en <= 1'b1;
        repeat (14) @(posedge pclk);
        sample_en <= 1'b0;
        @(posedge pclk);
        check(32'h0, {31'h0, play.valid});
        adv_trigger <= 1'b1;
        @(posedge pclk);
        adv_trigger <= 1'b0;
        rd(stm_pkg::OFF_PLAY_POS, 32'h3);
        wrap_up;
    end
endmodule : test_sequence_table_manager
